// ===== inc/urwaf_pkg.sv
// Shared constants, types and helpers for the wake and address filter link
package urwaf_pkg;

  localparam int          REF_CLK_HZ        = 20_000_000;
  localparam logic [4:0]  SPB_NORMAL        = 5'h10;
  localparam logic [4:0]  SPB_DOUBLE        = 5'h08;
  localparam logic [4:0]  VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0]  VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0]  VOTE_SPAN         = 5'h02;
  localparam logic [2:0]  CHAR_SIZE_9BIT    = 3'h7;
  localparam logic        FRAME_ADDR        = 1'b1;
  localparam logic        LINE_IDLE         = 1'b1;
  localparam logic [8:0]  RX_DATA_RST       = 9'h000;
  localparam logic [11:0] BAUD_DIV_RST      = 12'h000;

  // Synchronous wake limits: quarter of the system clock from idle,
  // a fixed bit rate from the deep sleep modes
  localparam int          SYNC_IDLE_DIV      = 4;
  localparam logic [12:0] SYNC_IDLE_MIN_HALF = 13'(SYNC_IDLE_DIV / 2);
  localparam int          SYNC_DEEP_MAX_BPS  = 500_000;
  localparam logic [12:0] SYNC_DEEP_MIN_HALF =
    13'((REF_CLK_HZ + 2 * SYNC_DEEP_MAX_BPS - 1) / (2 * SYNC_DEEP_MAX_BPS));

  // Rate error budgets for 8-bit frames, hundredths of a percent
  localparam int NORMAL_RATE_BPS     = 115_200;
  localparam int NORMAL_ERR_POS      = 315;
  localparam int NORMAL_ERR_NEG      = 400;
  localparam int DOUBLE_RATE_BPS     = 57_600;
  localparam int DOUBLE_ERR_POS      = 390;
  localparam int DOUBLE_ERR_NEG      = 270;
  localparam int END_SHARE_ERR_9BITS = 150;

  typedef enum logic [2:0]
  {
    RX_IDLE   = 3'h0,
    RX_START  = 3'h1,
    RX_DATA   = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP   = 3'h6
  } urwaf_rx_state_t;

  typedef enum logic
  {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } urwaf_tx_state_t;

  function automatic logic [3:0] urwaf_char_bits(input logic [2:0] code);
    case (code)
      3'h0:    urwaf_char_bits = 4'h5;
      3'h1:    urwaf_char_bits = 4'h6;
      3'h2:    urwaf_char_bits = 4'h7;
      3'h7:    urwaf_char_bits = 4'h9;
      default: urwaf_char_bits = 4'h8;
    endcase
  endfunction

  function automatic logic urwaf_parity(input logic [8:0] d,
                                        input logic [3:0] nb,
                                        input logic       odd);
    logic [8:0] mask;
    mask = 9'h1FF >> (4'h9 - nb);
    urwaf_parity = (^(d & mask)) ^ odd;
  endfunction

  function automatic logic urwaf_majority(input logic [2:0] s);
    urwaf_majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

endpackage

// ===== inc/urwaf_link_if.sv
// Serial link between the remote sender and the receiving device
`timescale 1ns/1ps
interface urwaf_link_if;
  logic serial_rx_line;
  logic serial_clk;

  modport device (input serial_rx_line, input serial_clk);
  modport remote (output serial_rx_line, output serial_clk);
endinterface

// ===== hw/urwaf_sampler.sv
// Oversampling tick and three-sample majority vote for async reception
`timescale 1ns/1ps
module urwaf_sampler
  import urwaf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        restart,
  input  wire logic        double_speed_select,
  input  wire logic [11:0] baud_divisor,
  input  wire logic        line,
  output logic             sample_tick,
  output logic             bit_done,
  output logic             bit_val
);

  logic [11:0] pre_reg;
  logic [4:0]  cnt_reg;
  logic [1:0]  smp_reg;
  logic [4:0]  spb;
  logic [4:0]  first;

  assign sample_tick = (pre_reg == 12'h000);
  assign spb         = double_speed_select ? SPB_DOUBLE : SPB_NORMAL;
  assign first       = double_speed_select ? VOTE_FIRST_DOUBLE
                                           : VOTE_FIRST_NORMAL;
  assign bit_done    = sample_tick && (cnt_reg == first + VOTE_SPAN);
  assign bit_val     = urwaf_majority({smp_reg, line});

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      pre_reg <= BAUD_DIV_RST;
    else if (sample_tick)
      pre_reg <= baud_divisor;
    else
      pre_reg <= pre_reg - 12'h001;
  end

  // Counter holds the number of the sample about to be taken
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      cnt_reg <= 5'h01;
    else if (restart)
      cnt_reg <= 5'h02;
    else if (sample_tick)
      cnt_reg <= (cnt_reg == spb) ? 5'h01 : cnt_reg + 5'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      smp_reg <= 2'h0;
    else if (sample_tick && cnt_reg >= first && cnt_reg < first + VOTE_SPAN)
      smp_reg <= {smp_reg[0], line};
  end

endmodule

// ===== hw/urwaf_dev.sv
// Receiving end: start frame wake logic and address frame filter
`timescale 1ns/1ps
module urwaf_dev
  import urwaf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  urwaf_link_if.device     link,
  input  wire logic        rx_enable,
  input  wire logic        sync_mode,
  input  wire logic        double_speed_select,
  input  wire logic [2:0]  char_size_select,
  input  wire logic        parity_enable,
  input  wire logic        parity_odd,
  input  wire logic [11:0] baud_divisor,
  input  wire logic        start_frame_detect_enable,
  input  wire logic        rx_start_irq_enable,
  input  wire logic        multiproc_filter_enable,
  input  wire logic        sleep_active,
  input  wire logic        data_read,
  output logic [7:0]       serial_data_buffer,
  output logic             rx_ninth_bit,
  output logic             rx_complete_flag,
  output logic             frame_error_flag,
  output logic             parity_error_flag,
  output logic             overrun_flag,
  output logic             rx_start_irq,
  output logic             osc_power_up,
  output logic             serial_clk_enable,
  output logic             core_clk_enable
);

  urwaf_rx_state_t state_reg;
  logic [3:0]      bit_cnt_reg;
  logic [8:0]      shift_reg;
  logic            par_reg;
  logic            line_q_reg;
  logic            sclk_q_reg;
  logic            sleep_q_reg;
  logic            prev_smp_reg;
  logic [7:0]      serial_data_buffer_reg;
  logic            rx_ninth_bit_reg;
  logic            rx_complete_flag_reg;
  logic            frame_error_flag_reg;
  logic            parity_error_flag_reg;
  logic            overrun_flag_reg;
  logic            rx_start_irq_reg;
  logic            osc_power_up_reg;
  logic            serial_clk_enable_reg;
  logic            core_clk_enable_reg;

  logic            line;
  logic            line_fall;
  logic            sclk_rise;
  logic            wake_now;
  logic            start_irq_now;
  logic            rx_ok;
  logic            start_hit;
  logic            smp_tick;
  logic            smp_done;
  logic            smp_val;
  logic            bd;
  logic            bv;
  logic [3:0]      nb;
  logic            nine;
  logic            frame_type;
  logic            keep;
  logic            finish;
  logic            store;
  logic            buf_full;
  logic            frame_end;
  logic            false_start;

  assign line      = link.serial_rx_line;
  assign line_fall = line_q_reg && !line;
  assign sclk_rise = link.serial_clk && !sclk_q_reg;

  // The edge itself is seen on the line, independent of frame mode
  assign wake_now = sleep_active && start_frame_detect_enable &&
                    line_fall && !serial_clk_enable_reg;
  assign start_irq_now = start_frame_detect_enable && rx_start_irq_enable &&
                         rx_enable && line_fall &&
                         (state_reg == RX_IDLE);

  // Asleep and not woken, the receiver has no clock and sees nothing
  assign rx_ok = rx_enable &&
                 (!sleep_active || serial_clk_enable_reg || wake_now);

  assign start_hit = rx_ok && (state_reg == RX_IDLE) &&
                     (sync_mode ? (sclk_rise && !line)
                                : (smp_tick && !line && prev_smp_reg));

  assign bd = sync_mode ? sclk_rise : smp_done;
  assign bv = sync_mode ? line : smp_val;

  assign nb   = urwaf_char_bits(char_size_select);
  assign nine = (char_size_select == CHAR_SIZE_9BIT);

  assign frame_type = nine ? shift_reg[8] : bv;
  // Filter bit is toggled by software around the addressed burst
  assign keep   = !multiproc_filter_enable ||
                  (frame_type == FRAME_ADDR);
  assign finish = (state_reg == RX_STOP) && bd;
  // Only the receive path is gated; nothing here reaches a sender
  assign store  = finish && keep;
  assign buf_full  = rx_complete_flag_reg && !data_read;
  assign frame_end = finish || ((state_reg == RX_START) && bd && bv);

  // A glitch that never became a frame must not keep the clocks alive
  assign false_start = (state_reg == RX_IDLE) && line && !wake_now &&
                       (sync_mode ? sclk_rise : smp_tick);

  urwaf_sampler u_sampler
  (
    .ref_clk             (ref_clk),
    .rst_b               (rst_b),
    .restart             (start_hit && !sync_mode),
    .double_speed_select (double_speed_select),
    .baud_divisor        (baud_divisor),
    .line                (line),
    .sample_tick         (smp_tick),
    .bit_done            (smp_done),
    .bit_val             (smp_val)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      line_q_reg   <= LINE_IDLE;
      sclk_q_reg   <= 1'b0;
      sleep_q_reg  <= 1'b0;
      prev_smp_reg <= LINE_IDLE;
    end
    else
    begin
      line_q_reg  <= line;
      sclk_q_reg  <= link.serial_clk;
      sleep_q_reg <= sleep_active;
      if (smp_tick)
        prev_smp_reg <= line;
    end
  end

  // Sync frames have no voted start bit, so they skip the start state
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !rx_enable)
      state_reg <= RX_IDLE;
    else
    begin
      case (state_reg)
        RX_IDLE:
          if (start_hit)
            state_reg <= sync_mode ? RX_DATA : RX_START;
        RX_START:
          if (bd)
            state_reg <= bv ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (bd && bit_cnt_reg == nb - 4'h1)
            state_reg <= parity_enable ? RX_PARITY : RX_STOP;
        RX_PARITY:
          if (bd)
            state_reg <= RX_STOP;
        RX_STOP:
          if (bd)
            state_reg <= RX_IDLE;
        default:
          state_reg <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      shift_reg   <= RX_DATA_RST;
      bit_cnt_reg <= 4'h0;
      par_reg     <= 1'b0;
    end
    else if (start_hit)
    begin
      shift_reg   <= RX_DATA_RST;
      bit_cnt_reg <= 4'h0;
    end
    else if (state_reg == RX_DATA && bd)
    begin
      shift_reg[bit_cnt_reg] <= bv;
      bit_cnt_reg            <= bit_cnt_reg + 4'h1;
    end
    else if (state_reg == RX_PARITY && bd)
      par_reg <= bv;
  end

  // One-entry buffer; a frame arriving while it is full is lost
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      serial_data_buffer_reg <= RX_DATA_RST[7:0];
      rx_ninth_bit_reg       <= 1'b0;
      frame_error_flag_reg   <= 1'b0;
      parity_error_flag_reg  <= 1'b0;
      overrun_flag_reg       <= 1'b0;
    end
    else if (store && buf_full)
      overrun_flag_reg <= 1'b1;
    else if (store)
    begin
      serial_data_buffer_reg <= shift_reg[7:0];
      rx_ninth_bit_reg       <= shift_reg[8];
      frame_error_flag_reg   <= !bv;
      parity_error_flag_reg  <= parity_enable &&
        (par_reg != urwaf_parity(shift_reg, nb, parity_odd));
      overrun_flag_reg       <= 1'b0;
    end
  end

  // Set wins over a read in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !rx_enable)
      rx_complete_flag_reg <= 1'b0;
    else if (store)
      rx_complete_flag_reg <= 1'b1;
    else if (data_read)
      rx_complete_flag_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      osc_power_up_reg      <= 1'b0;
      serial_clk_enable_reg <= 1'b0;
    end
    else if (wake_now)
    begin
      osc_power_up_reg      <= 1'b1;
      serial_clk_enable_reg <= 1'b1;
    end
    else if (frame_end || false_start || !sleep_active)
    begin
      osc_power_up_reg      <= 1'b0;
      serial_clk_enable_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rx_start_irq_reg <= 1'b0;
    else
      rx_start_irq_reg <= start_irq_now;
  end

  // Core clocks stay off in sleep until a start irq or a stored frame
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !sleep_active)
      core_clk_enable_reg <= 1'b1;
    else if (start_irq_now || store)
      core_clk_enable_reg <= 1'b1;
    else if (!sleep_q_reg)
      core_clk_enable_reg <= 1'b0;
  end

  assign serial_data_buffer = serial_data_buffer_reg;
  assign rx_ninth_bit       = rx_ninth_bit_reg;
  assign rx_complete_flag   = rx_complete_flag_reg;
  assign frame_error_flag   = frame_error_flag_reg;
  assign parity_error_flag  = parity_error_flag_reg;
  assign overrun_flag       = overrun_flag_reg;
  assign rx_start_irq       = rx_start_irq_reg;
  assign osc_power_up       = osc_power_up_reg;
  assign serial_clk_enable  = serial_clk_enable_reg;
  assign core_clk_enable    = core_clk_enable_reg;

endmodule

// ===== hw/urwaf_remote.sv
// Sending end: master transmitter that marks address and data frames
`timescale 1ns/1ps
module urwaf_remote
  import urwaf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  urwaf_link_if.remote     link,
  input  wire logic        tx_valid,
  input  wire logic [8:0]  tx_data,
  input  wire logic        tx_is_address,
  input  wire logic [2:0]  char_size_select,
  input  wire logic        parity_enable,
  input  wire logic        parity_odd,
  input  wire logic        two_stop_select,
  input  wire logic        multiproc_mark,
  input  wire logic        sync_mode,
  input  wire logic        double_speed_select,
  input  wire logic        wake_from_deep,
  input  wire logic [11:0] baud_divisor,
  output logic             tx_ready
);

  urwaf_tx_state_t state_reg;
  logic [12:0]     frame_reg;
  logic [3:0]      left_reg;
  logic [16:0]     tmr_reg;
  logic            line_reg;
  logic            sclk_reg;
  logic            tx_ready_reg;

  logic [3:0]      nb;
  logic            short_mark;
  logic [8:0]      data9;
  logic [12:0]     frame;
  logic [3:0]      pos;
  logic [3:0]      frame_len;
  logic [12:0]     div_half;
  logic [12:0]     min_half;
  logic [12:0]     half;
  logic [16:0]     bit_len;

  assign nb         = urwaf_char_bits(char_size_select);
  assign short_mark = multiproc_mark && (nb != 4'h9);
  assign data9      = {(multiproc_mark && nb == 4'h9) ? tx_is_address
                                                      : tx_data[8],
                       tx_data[7:0]};

  // Sync clock never faster than the waking receiver can follow
  assign div_half = {1'b0, baud_divisor} + 13'h0001;
  assign min_half = wake_from_deep ? SYNC_DEEP_MIN_HALF
                                   : SYNC_IDLE_MIN_HALF;
  assign half     = (div_half < min_half) ? min_half : div_half;
  // Divisor choice keeps this end within its half of the budget
  assign bit_len  = sync_mode ? {3'h0, half, 1'b0}
                  : 17'(({5'h00, baud_divisor} + 17'h00001) *
                        (double_speed_select ? 17'h00008 : 17'h00010));

  always_comb
  begin
    frame    = 13'h1FFF;
    frame[0] = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      if (4'(i) < nb)
        frame[i + 1] = data9[i];
    end
    pos = nb + 4'h1;
    if (parity_enable)
    begin
      frame[pos] = urwaf_parity(data9, nb, parity_odd);
      pos        = pos + 4'h1;
    end
    // In short marked frames the first stop carries the frame type and a second stop follows it
    frame[pos] = short_mark ? tx_is_address : 1'b1;
    frame_len  = pos + 4'h1 +
                 ((two_stop_select || short_mark) ? 4'h1 : 4'h0);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_reg    <= TX_IDLE;
      frame_reg    <= 13'h1FFF;
      left_reg     <= 4'h0;
      tmr_reg      <= 17'h00000;
      line_reg     <= LINE_IDLE;
      tx_ready_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        TX_IDLE:
        begin
          tx_ready_reg <= 1'b1;
          if (tx_valid && tx_ready_reg)
          begin
            frame_reg    <= frame;
            left_reg     <= frame_len;
            tmr_reg      <= bit_len - 17'h00001;
            line_reg     <= frame[0];
            tx_ready_reg <= 1'b0;
            state_reg    <= TX_SEND;
          end
        end
        TX_SEND:
          if (tmr_reg != 17'h00000)
            tmr_reg <= tmr_reg - 17'h00001;
          else if (left_reg == 4'h1)
          begin
            line_reg     <= LINE_IDLE;
            tx_ready_reg <= 1'b1;
            state_reg    <= TX_IDLE;
          end
          else
          begin
            frame_reg <= {1'b1, frame_reg[12:1]};
            line_reg  <= frame_reg[1];
            left_reg  <= left_reg - 4'h1;
            tmr_reg   <= bit_len - 17'h00001;
          end
        default:
          state_reg <= TX_IDLE;
      endcase
    end
  end

  // Rising serial clock lands mid-bit; it runs only inside frames
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      sclk_reg <= 1'b0;
    else
      sclk_reg <= sync_mode && (state_reg == TX_SEND) &&
                  (tmr_reg < {4'h0, half}) &&
                  !(tmr_reg == 17'h00000 && left_reg == 4'h1);
  end

  assign link.serial_rx_line = line_reg;
  assign link.serial_clk     = sclk_reg;
  assign tx_ready            = tx_ready_reg;

endmodule

// ===== tb/urwaf_checker.sv
// Link and wake assertions for the wake and address filter link
`timescale 1ns/1ps
module urwaf_checker
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic serial_rx_line,
  input wire logic serial_clk,
  input wire logic tx_ready,
  input wire logic rx_enable,
  input wire logic sleep_active,
  input wire logic start_frame_detect_enable,
  input wire logic rx_start_irq_enable,
  input wire logic data_read,
  input wire logic rx_complete_flag,
  input wire logic rx_start_irq,
  input wire logic osc_power_up,
  input wire logic serial_clk_enable,
  input wire logic core_clk_enable
);
  logic [5:0] rdy_cnt_reg;

  // Cycles the sender has been idle; stores are long over after 16
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !tx_ready)
      rdy_cnt_reg <= 6'h00;
    else if (rdy_cnt_reg != 6'h3F)
      rdy_cnt_reg <= rdy_cnt_reg + 6'h01;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_wake_clk_on: assert property (
    sleep_active && start_frame_detect_enable && rx_enable && !osc_power_up
    && $fell(serial_rx_line) |-> ##[1:3] (osc_power_up && serial_clk_enable))
    else $error("wake edge did not start the clocks");
  a_no_wake_off: assert property (
    sleep_active && !start_frame_detect_enable && !osc_power_up
    |=> !osc_power_up) else $error("clock woke without detect enable");
  a_irq_wake: assert property (
    sleep_active && start_frame_detect_enable && rx_start_irq_enable
    && rx_enable && !osc_power_up && $fell(serial_rx_line)
    |-> ##[1:3] rx_start_irq) else $error("start irq missing");
  a_irq_needs_en: assert property (
    rx_start_irq |-> $past(rx_start_irq_enable)
    && $past(start_frame_detect_enable)) else $error("irq not enabled");
  a_irq_one_pulse: assert property (
    rx_start_irq |=> !rx_start_irq) else $error("irq longer than a pulse");
  a_core_sleeps: assert property (
    $rose(sleep_active) |-> ##[1:2] !core_clk_enable)
    else $error("core clock kept running in sleep");
  a_core_awake: assert property (
    !sleep_active [*3] |-> core_clk_enable) else $error("core clock off");
  a_irq_core_on: assert property (
    sleep_active && rx_start_irq |-> ##[0:2] core_clk_enable)
    else $error("irq did not wake the core");
  a_read_clears: assert property (
    data_read && rdy_cnt_reg >= 6'h10 |=> !rx_complete_flag)
    else $error("read left complete flag set");
  a_link_idle: assert property (
    tx_ready |-> serial_rx_line && !serial_clk)
    else $error("link not idle between frames");
  a_start_bit: assert property (
    $fell(tx_ready) |-> !serial_rx_line) else $error("no start bit");
endmodule

// ===== tb/urwaf_tb.sv
// Self-checking bench joining the sender and the receiving device
`timescale 1ns/1ps
module urwaf_tb
  import urwaf_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rx_enable = 1'b1;
  logic        sync_mode = 1'b0;
  logic        double_speed_select = 1'b0;
  logic [2:0]  char_size_select = 3'h3;
  logic        parity_enable = 1'b0;
  logic        parity_odd = 1'b0;
  logic [11:0] baud_divisor = 12'h000;
  logic        start_frame_detect_enable = 1'b0;
  logic        rx_start_irq_enable = 1'b0;
  logic        multiproc_filter_enable = 1'b0;
  logic        sleep_active = 1'b0;
  logic        data_read = 1'b0;
  logic        tx_valid = 1'b0;
  logic [8:0]  tx_data = 9'h000;
  logic        tx_is_address = 1'b0;
  logic        two_stop_select = 1'b0;
  logic        multiproc_mark = 1'b0;
  logic        wake_from_deep = 1'b0;
  logic [7:0]  serial_data_buffer;
  logic        rx_ninth_bit, rx_complete_flag, frame_error_flag;
  logic        parity_error_flag, overrun_flag, rx_start_irq;
  logic        osc_power_up, serial_clk_enable, core_clk_enable, tx_ready;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          irq_cnt = 0;
  int          tnum = 0;
  logic        osc_seen = 1'b0;
  logic        pend = 1'b0;
  logic [8:0]  old_exp = 9'h000;
  logic [31:0] lfsr = 32'h3D585159;
  logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};

  urwaf_link_if link();
  urwaf_dev i_urwaf_dev (.ref_clk, .rst_b, .link(link), .rx_enable,
    .sync_mode, .double_speed_select, .char_size_select, .parity_enable,
    .parity_odd, .baud_divisor, .start_frame_detect_enable,
    .rx_start_irq_enable, .multiproc_filter_enable, .sleep_active,
    .data_read, .serial_data_buffer, .rx_ninth_bit, .rx_complete_flag,
    .frame_error_flag, .parity_error_flag, .overrun_flag, .rx_start_irq,
    .osc_power_up, .serial_clk_enable, .core_clk_enable);
  urwaf_remote i_urwaf_remote (.ref_clk, .rst_b, .link(link), .tx_valid,
    .tx_data, .tx_is_address, .char_size_select, .parity_enable,
    .parity_odd, .two_stop_select, .multiproc_mark, .sync_mode,
    .double_speed_select, .wake_from_deep, .baud_divisor, .tx_ready);
  urwaf_checker i_urwaf_checker (.ref_clk, .rst_b,
    .serial_rx_line(link.serial_rx_line), .serial_clk(link.serial_clk),
    .tx_ready, .rx_enable, .sleep_active, .start_frame_detect_enable,
    .rx_start_irq_enable, .data_read, .rx_complete_flag, .rx_start_irq,
    .osc_power_up, .serial_clk_enable, .core_clk_enable);

  always #25 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Character length sets how many low data bits survive the trip
  function automatic logic [8:0] exp_data(input logic [8:0] d,
                                          input logic [2:0] code);
    case (code)
      3'h0:    exp_data = d & 9'h01F;
      3'h1:    exp_data = d & 9'h03F;
      3'h2:    exp_data = d & 9'h07F;
      3'h7:    exp_data = d;
      default: exp_data = d & 9'h0FF;
    endcase
  endfunction

  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({8'h00, got}, {8'h00, exp});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_ready();
    while (tx_ready !== 1'b1)
      @(posedge ref_clk);
  endtask

  task automatic run_frame(input logic [2:0] code, input logic dss,
                           input logic syn, input logic filt,
                           input logic addr, input logic sl,
                           input logic sfd, input logic ie,
                           input logic store, input logic rd);
    logic [8:0] e;
    int         irq0;
    lfsr = lfsr_step(lfsr);
    e = exp_data(lfsr[8:0], code);
    if (code == CHAR_SIZE_9BIT)
      e[8] = addr;
    irq0 = irq_cnt;
    tnum++;
    @(posedge ref_clk);
    char_size_select <= code;
    double_speed_select <= dss;
    sync_mode <= syn;
    multiproc_filter_enable <= filt;
    // Short marked frames need a second stop, the first carries the type
    multiproc_mark <= filt || code == CHAR_SIZE_9BIT;
    two_stop_select <= lfsr[9] || filt;
    parity_enable <= lfsr[10];
    parity_odd <= lfsr[11];
    wake_from_deep <= lfsr[12];
    baud_divisor <= {10'h000, lfsr[14:13]};
    sleep_active <= sl;
    start_frame_detect_enable <= sfd;
    rx_start_irq_enable <= ie;
    repeat (4) @(posedge ref_clk);
    osc_seen = 1'b0;
    if (sl)
      chk_bit(core_clk_enable, 1'b0);
    wait_ready();
    tx_valid <= 1'b1;
    tx_data <= lfsr[8:0];
    tx_is_address <= addr;
    @(posedge ref_clk);
    tx_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    wait_ready();
    repeat (64) @(posedge ref_clk);
    chk_bit(rx_complete_flag, store || pend);
    chk_bit(osc_seen, sl && sfd);
    chk_bit(irq_cnt != irq0, sfd && ie);
    chk_bit(core_clk_enable, !sl || store || (sfd && ie));
    chk_bit(osc_power_up | serial_clk_enable, 1'b0);
    if (store)
    begin
      chk_val({rx_ninth_bit, serial_data_buffer}, pend ? old_exp : e);
      chk_bit(overrun_flag, pend);
      chk_bit(frame_error_flag | parity_error_flag, 1'b0);
      if (!pend)
        old_exp = e;
      pend = 1'b1;
    end
    else
    begin
      chk_bit(frame_error_flag | overrun_flag, 1'b0);
      chk_val({rx_ninth_bit, serial_data_buffer}, old_exp);
    end
    if (rd)
    begin
      data_read <= 1'b1;
      @(posedge ref_clk);
      data_read <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk_bit(rx_complete_flag, 1'b0);
      pend = 1'b0;
    end
    sleep_active <= 1'b0;
    $display("test %0d done", tnum);
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (rx_start_irq === 1'b1)
      irq_cnt++;
    if (osc_power_up === 1'b1)
      osc_seen = 1'b1;
    if (cycles > 60000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_bit(rx_complete_flag, 1'b0);
    for (int m = 0; m < 3; m++)
      for (int i = 0; i < 6; i++)
        run_frame(codes[i], m == 1, m == 2, 0, 0, 0, 0, 0, 1, 1);
    run_frame(3'h7, 0, 0, 1, 0, 0, 0, 0, 0, 1);
    run_frame(3'h7, 0, 0, 1, 1, 0, 0, 0, 1, 1);
    run_frame(3'h7, 0, 0, 0, 0, 0, 0, 0, 1, 1);
    run_frame(3'h2, 0, 1, 1, 0, 0, 0, 0, 0, 1);
    run_frame(3'h2, 0, 0, 1, 1, 0, 0, 0, 1, 1);
    run_frame(3'h3, 0, 0, 0, 0, 1, 0, 0, 0, 1);
    run_frame(3'h3, 0, 0, 0, 0, 1, 1, 1, 1, 1);
    run_frame(3'h1, 0, 1, 0, 0, 1, 1, 0, 1, 1);
    run_frame(3'h3, 0, 0, 0, 0, 0, 0, 0, 1, 0);
    run_frame(3'h3, 1, 0, 0, 0, 0, 0, 0, 1, 1);
    // Disabling the receiver clears the complete flag of an unread frame
    run_frame(3'h3, 0, 0, 0, 0, 0, 0, 0, 1, 0);
    rx_enable <= 1'b0;
    @(posedge ref_clk);
    rx_enable <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk_bit(rx_complete_flag, 1'b0);
    pend = 1'b0;
    run_frame(3'h3, 0, 1, 0, 0, 0, 1, 1, 1, 1);
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_step(lfsr);
      run_frame(codes[lfsr[17:15] % 6], lfsr[18], lfsr[19], 0, 0, 0, 0, 0,
                1, 1);
    end
    give_verdict();
  end
endmodule
